// >>> hdl/pscn_scan_engine.sv
`timescale 1ns/10ps
`default_nettype none
module pscn_scan_engine
   import pscn_pkg::*;
#(
   parameter int CHAN_LEN = CHAN_LEN_DEF,
   parameter int GLOBAL_LEN = GLOBAL_LEN_DEF
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_wdata_in,
   output logic [31:0] reg_rdata_out,
   output logic busy_out,
   input wire logic [NUM_LANES-1:0] scan_data_in,
   output logic [NUM_LANES-1:0] scan_shift_en_out,
   output logic [NUM_LANES-1:0] scan_data_out,
   output logic [NUM_LANES-1:0] scan_recirc_out,
   output logic [NUM_LANES-1:0] scan_update_out
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SHIFT,
      ST_DRAIN,
      ST_UPDATE,
      ST_FINISH
   } pscn_state_t;

   pscn_state_t state_reg;
   logic [31:0] select_reg;
   logic [15:0] count_field_reg;
   logic rd_cmd_reg;
   logic wr_cmd_reg;
   logic [DATA_W-1:0] scan_chain_data_reg;
   logic [DATA_W-1:0] tx_reg;
   logic [5:0] tx_left_reg;
   pscn_mode_t mode_reg;
   logic [1:0] op_sel_reg;
   logic pin_shift_reg;
   logic busy_reg;

   logic wr_select;
   logic wr_control;
   logic wr_data;
   logic start_rd;
   logic start_wr;
   logic start_any;
   logic [15:0] limit;
   logic [15:0] eff_count;
   logic [15:0] remaining;
   logic last_shift;
   logic shifting;
   logic sel_sin;
   pscn_bit_req_t bit_req;
   pscn_chain_drv_t drv;

   // Chain length plus index pad for the chosen code; reserved code shifts nothing
   function automatic logic [15:0] chain_limit(input logic [1:0] sel);
      logic [15:0] len;
      len = 16'h0000;
      unique case (sel)
         SEL_CHAN0: len = 16'(CHAN_LEN) + INDEX_PAD;
         SEL_CHAN1: len = 16'(CHAN_LEN) + INDEX_PAD;
         SEL_GLOBAL: len = 16'(GLOBAL_LEN) + INDEX_PAD;
         SEL_RSVD: len = 16'h0000;
      endcase
      return len;
   endfunction

   // Register write decode
   assign wr_select = reg_wr_in && reg_addr_in == SELECT_OFS && !busy_reg;
   assign wr_control = reg_wr_in && reg_addr_in == CONTROL_OFS && !busy_reg;
   assign wr_data = reg_wr_in && reg_addr_in == DATA_OFS && !busy_reg;

   // Command start; read takes priority when both bits are written
   assign start_rd = wr_control && reg_wdata_in[CTL_RD_BIT];
   assign start_wr = wr_control && reg_wdata_in[CTL_WR_BIT] && !start_rd;
   assign start_any = start_rd || start_wr;

   // Count bounded by the selected chain plus index pad
   assign limit = chain_limit(select_reg[SEL_MSB:SEL_LSB]);
   assign eff_count = (reg_wdata_in[CNT_W-1:0] > limit) ? limit : reg_wdata_in[CNT_W-1:0];

   assign shifting = (state_reg == ST_SHIFT);

   pscn_down_counter #(
      .W(CNT_W)
   ) u_count (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .load_in(start_any),
      .value_in(eff_count),
      .dec_in(shifting),
      .value_out(remaining),
      .last_out(last_shift)
   );

   // Select register
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         select_reg <= SELECT_RST;
      end else if (wr_select) begin
         select_reg <= '0;
         select_reg[SEL_MSB:SEL_LSB] <= reg_wdata_in[SEL_MSB:SEL_LSB];
      end
   end

   // Control register count field
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         count_field_reg <= COUNT_RST;
      end else if (wr_control) begin
         count_field_reg <= reg_wdata_in[CNT_W-1:0];
      end
   end

   // Command bits, set by software and cleared by the engine
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         rd_cmd_reg <= 1'b0;
         wr_cmd_reg <= 1'b0;
      end else if (start_any) begin
         rd_cmd_reg <= start_rd;
         wr_cmd_reg <= start_wr;
      end else if (state_reg == ST_FINISH) begin
         rd_cmd_reg <= 1'b0;
         wr_cmd_reg <= 1'b0;
      end
   end

   // Operation latch: mode and chain fixed for the whole shift
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         mode_reg <= PSCN_MODE_READ;
         op_sel_reg <= SEL_CHAN0;
      end else if (start_any) begin
         mode_reg <= start_wr ? PSCN_MODE_WRITE : PSCN_MODE_READ;
         op_sel_reg <= select_reg[SEL_MSB:SEL_LSB];
      end
   end

   // Sequencer
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         state_reg <= ST_IDLE;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (start_any) begin
                  state_reg <= (eff_count == 16'h0000) ? ST_FINISH : ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (last_shift) begin
                  state_reg <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               state_reg <= (mode_reg == PSCN_MODE_WRITE) ? ST_UPDATE : ST_FINISH;
            end
            ST_UPDATE: begin
               state_reg <= ST_FINISH;
            end
            ST_FINISH: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Busy from command accept until the command bit drops
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         busy_reg <= 1'b0;
      end else if (start_any) begin
         busy_reg <= 1'b1;
      end else if (state_reg == ST_FINISH) begin
         busy_reg <= 1'b0;
      end
   end

   // Write payload, sent least significant bit first
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         tx_reg <= '0;
         tx_left_reg <= 6'h00;
      end else if (start_wr) begin
         tx_reg <= scan_chain_data_reg;
         tx_left_reg <= 6'h20;
      end else if (state_reg == ST_FINISH) begin
         // Drop leftover payload so idle pins stay quiet
         tx_reg <= '0;
         tx_left_reg <= 6'h00;
      end else if (shifting && mode_reg == PSCN_MODE_WRITE && tx_left_reg != 6'h00) begin
         tx_reg <= {1'b0, tx_reg[DATA_W-1:1]};
         tx_left_reg <= tx_left_reg - 6'h01;
      end
   end

   // Bit request: payload first, chain recirculates otherwise
   always_comb begin
      bit_req = '0;
      bit_req.shift = shifting;
      if (mode_reg == PSCN_MODE_WRITE && tx_left_reg != 6'h00) begin
         bit_req.sbit = shifting && tx_reg[0];
         bit_req.recirc = 1'b0;
      end else begin
         bit_req.recirc = shifting;
      end
      // Shadow transfer; mask and halt bits in each section gate it
      bit_req.update = (state_reg == ST_UPDATE);
   end

   pscn_chain_port u_port (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .sel_in(op_sel_reg),
      .req_in(bit_req),
      .scan_data_in(scan_data_in),
      .drv_out(drv),
      .sel_sin_out(sel_sin)
   );

   // Tracks the cycle in which the chain pins shift
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         pin_shift_reg <= 1'b0;
      end else begin
         pin_shift_reg <= shifting;
      end
   end

   // Data register: software load or read capture
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         scan_chain_data_reg <= DATA_RST;
      end else if (wr_data) begin
         scan_chain_data_reg <= reg_wdata_in;
      end else if (pin_shift_reg && mode_reg == PSCN_MODE_READ) begin
         // Last 32 bits out leave the addressed section lowest
         scan_chain_data_reg <= {sel_sin, scan_chain_data_reg[DATA_W-1:1]};
      end
   end

   // Register read return, one cycle after the strobe
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            SELECT_OFS: reg_rdata_out <= select_reg;
            CONTROL_OFS: reg_rdata_out <= {rd_cmd_reg, wr_cmd_reg, 14'h0000, count_field_reg};
            DATA_OFS: reg_rdata_out <= scan_chain_data_reg;
            default: reg_rdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // Status pin mirrors the busy flop
   assign busy_out = busy_reg;

   // Chain pins, already registered in the router
   assign scan_shift_en_out = drv.shift_en;
   assign scan_data_out = drv.sdata;
   assign scan_recirc_out = drv.recirc;
   assign scan_update_out = drv.update;

   // Remaining count is only watched by the sequencer via last
   logic unused_ok;
   assign unused_ok = ^remaining;
endmodule
`default_nettype wire

// >>> hdl/pscn_pkg.sv
// Summary of operation
// - Four chain codes; two channels, one global.
// - Chain lengths 5261 and 539, as parameters.
// - Sections of at most 32 bits each.
// - Section is data bits plus mask, halt.
// - Mask zero blocks shadow register load.
// - Mask one loads; halt one holds value.
// - Select bits 26:25 choose chain; 10 reserved.
// - Read bit clears when read completes.
// - Read returns 32 bits, section lowest.
// - Write bit clears when write completes.
// - Lowest data bits enter chain first.
// - Training parameters reachable per channel, rank.
// - Bits 31, 30 are set-only read, write.
// - Control bits 15:0 hold shift count.
// - 32-bit data register, reset to zero.
package pscn_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] SELECT_OFS = 8'h5C;
   localparam logic [7:0] CONTROL_OFS = 8'hF8;
   localparam logic [7:0] DATA_OFS = 8'hFC;
   localparam int SEL_LSB = 25;
   localparam int SEL_MSB = 26;
   localparam int CTL_RD_BIT = 31;
   localparam int CTL_WR_BIT = 30;
   localparam int CNT_W = 16;
   localparam int DATA_W = 32;
   localparam int NUM_LANES = 3;
   localparam logic [31:0] SELECT_RST = 32'h0000_0000;
   localparam logic [31:0] DATA_RST = 32'h0000_0000;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam int CHAN_LEN_DEF = 5261;
   localparam int GLOBAL_LEN_DEF = 539;
   localparam logic [15:0] INDEX_PAD = 16'h0026;
   localparam logic [1:0] SEL_CHAN0 = 2'h0;
   localparam logic [1:0] SEL_CHAN1 = 2'h1;
   localparam logic [1:0] SEL_RSVD = 2'h2;
   localparam logic [1:0] SEL_GLOBAL = 2'h3;

   typedef enum logic {PSCN_MODE_READ, PSCN_MODE_WRITE} pscn_mode_t;

   // Per-lane drive toward the chains
   typedef struct packed {
      logic [NUM_LANES-1:0] shift_en;
      logic [NUM_LANES-1:0] sdata;
      logic [NUM_LANES-1:0] recirc;
      logic [NUM_LANES-1:0] update;
   } pscn_chain_drv_t;

   // One bit request from the engine to the lane router
   typedef struct packed {
      logic shift;
      logic sbit;
      logic recirc;
      logic update;
   } pscn_bit_req_t;

   // Chain select code to one-hot lane, reserved code gives none
   function automatic logic [NUM_LANES-1:0] pscn_lane_of(input logic [1:0] sel);
      logic [NUM_LANES-1:0] lane;
      lane = 3'h0;
      unique case (sel)
         SEL_CHAN0: lane = 3'h1;
         SEL_CHAN1: lane = 3'h2;
         SEL_GLOBAL: lane = 3'h4;
         SEL_RSVD: lane = 3'h0;
      endcase
      return lane;
   endfunction
endpackage

// >>> hdl/pscn_down_counter.sv
`timescale 1ns/10ps
`default_nettype none
module pscn_down_counter
   import pscn_pkg::*;
#(
   parameter int W = CNT_W
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic load_in,
   input wire logic [W-1:0] value_in,
   input wire logic dec_in,
   output logic [W-1:0] value_out,
   output logic last_out
);
   logic [W-1:0] count_reg;

   // Remaining shift count
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         count_reg <= '0;
      end else if (load_in) begin
         count_reg <= value_in;
      end else if (dec_in && count_reg != '0) begin
         count_reg <= count_reg - W'(1);
      end
   end

   assign value_out = count_reg;
   assign last_out = (count_reg == W'(1));
endmodule
`default_nettype wire

// >>> hdl/pscn_chain_port.sv
`timescale 1ns/10ps
`default_nettype none
module pscn_chain_port
   import pscn_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic [1:0] sel_in,
   input wire pscn_bit_req_t req_in,
   input wire logic [NUM_LANES-1:0] scan_data_in,
   output pscn_chain_drv_t drv_out,
   output logic sel_sin_out
);
   logic [NUM_LANES-1:0] lane;

   assign lane = pscn_lane_of(sel_in);

   // Registered drive of the selected lane only
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         drv_out <= '0;
      end else begin
         drv_out.shift_en <= req_in.shift ? lane : 3'h0;
         drv_out.sdata <= req_in.sbit ? lane : 3'h0;
         drv_out.recirc <= req_in.recirc ? lane : 3'h0;
         drv_out.update <= req_in.update ? lane : 3'h0;
      end
   end

   // Serial bit leaving the chain now being shifted
   assign sel_sin_out = |(scan_data_in & drv_out.shift_en);
endmodule
`default_nettype wire

// >>> verif/pscn_chain_model.sv
`timescale 1ns/10ps
`default_nettype none
module pscn_chain_model
   import pscn_pkg::*;
#(
   parameter int CHAN_LEN = 40,
   parameter int GLOBAL_LEN = 24
) (
   input wire logic ref_clk_in,
   input wire logic [NUM_LANES-1:0] shift_en_in,
   input wire logic [NUM_LANES-1:0] sdata_in,
   input wire logic [NUM_LANES-1:0] recirc_in,
   input wire logic [NUM_LANES-1:0] update_in,
   output logic [NUM_LANES-1:0] sdata_out
);
   logic [CHAN_LEN-1:0] ch_reg [NUM_LANES];
   logic [31:0] shadow_reg [NUM_LANES];
   logic [NUM_LANES-1:0] held_reg = 3'h0;
   logic [NUM_LANES-1:0] tail;
   // Seed chains with a known pattern
   initial begin
      for (int i = 0; i < NUM_LANES; i++) begin
         for (int b = 0; b < CHAN_LEN; b++) begin
            ch_reg[i][b] = b[0];
         end
      end
   end
   // Serial tail; inverted when not shifting
   always_comb begin
      tail[0] = ch_reg[0][CHAN_LEN-1];
      tail[1] = ch_reg[1][CHAN_LEN-1];
      tail[2] = ch_reg[2][GLOBAL_LEN-1];
      sdata_out = tail ^ ~shift_en_in;
   end
   // Shift one bit, own tail fed back when recirculating
   always @(posedge ref_clk_in) begin
      for (int i = 0; i < NUM_LANES; i++) begin
         if (shift_en_in[i]) begin
            ch_reg[i] <= {ch_reg[i][CHAN_LEN-2:0], recirc_in[i] ? tail[i] : sdata_in[i]};
         end
      end
   end
   // Shadow load: bit 1 mask, bit 0 halt
   always @(posedge ref_clk_in) begin
      for (int i = 0; i < NUM_LANES; i++) begin
         if (update_in[i] && ch_reg[i][1] && (!held_reg[i] || !ch_reg[i][0])) begin
            shadow_reg[i] <= ch_reg[i][31:0];
            held_reg[i] <= ch_reg[i][0];
         end
      end
   end
endmodule
`default_nettype wire

// >>> verif/pscn_scan_engine_properties.sv
`timescale 1ns/10ps
`default_nettype none
module pscn_scan_engine_properties
   import pscn_pkg::*;
#(
   parameter int CHAN_LEN = CHAN_LEN_DEF,
   parameter int GLOBAL_LEN = GLOBAL_LEN_DEF
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic busy_out,
   input wire logic [NUM_LANES-1:0] scan_data_in,
   input wire logic [NUM_LANES-1:0] scan_shift_en_out,
   input wire logic [NUM_LANES-1:0] scan_data_out,
   input wire logic [NUM_LANES-1:0] scan_recirc_out,
   input wire logic [NUM_LANES-1:0] scan_update_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   logic [1:0] sel_reg;
   logic [2:0] lane_w;
   // Select copy, busy writes dropped
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         sel_reg <= 2'h0;
      end else if (reg_wr_in && !busy_out && reg_addr_in == SELECT_OFS) begin
         sel_reg <= reg_wdata_in[SEL_MSB:SEL_LSB];
      end
   end
   assign lane_w = {sel_reg == SEL_GLOBAL, sel_reg == SEL_CHAN1, sel_reg == SEL_CHAN0};
   sequence s_cmd(int b);
      reg_wr_in && !busy_out && reg_addr_in == CONTROL_OFS && reg_wdata_in[b];
   endsequence
   sequence s_wr_go;
      s_cmd(CTL_WR_BIT) ##0 (!reg_wdata_in[CTL_RD_BIT] && reg_wdata_in[15:0] != 16'h0000
         && sel_reg != SEL_RSVD);
   endsequence
   sequence s_idle_cmd;
      (s_cmd(CTL_RD_BIT) or s_cmd(CTL_WR_BIT)) ##0 (reg_wdata_in[15:0] == 16'h0000 || sel_reg == SEL_RSVD);
   endsequence
   property p_busy_start;
      s_cmd(CTL_RD_BIT) or s_cmd(CTL_WR_BIT) |=> busy_out;
   endproperty
   property p_read_shift;
      s_cmd(CTL_RD_BIT) ##0 (reg_wdata_in[15:0] != 16'h0000 && sel_reg != SEL_RSVD)
         |-> ##2 (scan_shift_en_out == lane_w && scan_recirc_out == lane_w);
   endproperty
   property p_write_shift;
      s_wr_go |-> ##2 (scan_shift_en_out == lane_w && scan_recirc_out == 3'h0);
   endproperty
   property p_empty_cmd;
      s_idle_cmd |=> busy_out ##1 !busy_out;
   endproperty
   property p_shift_busy;
      scan_shift_en_out != 3'h0 |-> busy_out && scan_shift_en_out == lane_w;
   endproperty
   property p_upd_pulse;
      scan_update_out != 3'h0 |-> (busy_out && scan_update_out == lane_w)
         ##1 (scan_update_out == 3'h0 && !busy_out);
   endproperty
   property p_sel_read;
      reg_rd_in && reg_addr_in == SELECT_OFS |=> reg_rdata_out == {5'h00, sel_reg, 25'h0000000};
   endproperty
   property p_ctl_busy;
      reg_rd_in && reg_addr_in == CONTROL_OFS && busy_out |=> reg_rdata_out[31:30] != 2'h0;
   endproperty
   property p_reset;
      disable iff (1'b0) reset_in |=> busy_out == 1'b0 && scan_shift_en_out == 3'h0
         && scan_update_out == 3'h0 && reg_rdata_out == 32'h00000000;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy missing after command");
   a_read_shift: assert property (p_read_shift) else $error("read shift not on lane");
   a_write_shift: assert property (p_write_shift) else $error("write shift not on lane");
   a_empty_cmd: assert property (p_empty_cmd) else $error("empty command timing wrong");
   a_shift_busy: assert property (p_shift_busy) else $error("shift outside command");
   a_upd_pulse: assert property (p_upd_pulse) else $error("update not one pulse");
   a_sel_read: assert property (p_sel_read) else $error("select readback wrong");
   a_ctl_busy: assert property (p_ctl_busy) else $error("command bit clear while busy");
   a_reset: assert property (p_reset) else $error("outputs not idle in reset");
endmodule
`default_nettype wire

// >>> verif/pscn_scan_engine_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pscn_scan_engine_tb;
   import pscn_pkg::*;
   logic ref_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   wire logic [31:0] rdata;
   wire logic busy;
   wire logic [NUM_LANES-1:0] sin, sen, sout, rec, upd;
   int num_errors = 0;
   int n_tests = 0;
   logic [31:0] pat [3] = '{32'hA5C30F96, 32'h12345678, 32'hDEADBEEF};
   logic [31:0] rcmd [3] = '{32'h80000028, 32'h80000028, 32'h80000018};
   logic [1:0] code [3] = '{SEL_CHAN0, SEL_CHAN1, SEL_GLOBAL};
   initial forever #25 ref_clk_in = ~ref_clk_in;
   pscn_scan_engine #(.CHAN_LEN(40), .GLOBAL_LEN(24)) uut (.ref_clk_in(ref_clk_in),
      .reset_in(reset_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .busy_out(busy), .scan_data_in(sin),
      .scan_shift_en_out(sen), .scan_data_out(sout), .scan_recirc_out(rec),
      .scan_update_out(upd));
   pscn_chain_model #(.CHAN_LEN(40), .GLOBAL_LEN(24)) u_chain (.ref_clk_in(ref_clk_in),
      .shift_en_in(sen), .sdata_in(sout), .recirc_in(rec), .update_in(upd), .sdata_out(sin));
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk_in);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge ref_clk_in);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk_in);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] got;
      rd_reg(a, got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Read control back until both command bits clear
   task automatic poll();
      logic [31:0] v;
      for (int i = 0; i < 200; i++) begin
         rd_reg(CONTROL_OFS, v);
         if (v[31:30] === 2'b00) return;
      end
      num_errors++;
      complete_run();
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      chk(SELECT_OFS, SELECT_RST);
      chk(CONTROL_OFS, 32'h00000000);
      chk(DATA_OFS, DATA_RST);
      chk(8'h10, 32'h00000000);
      wr_reg(SELECT_OFS, 32'hFFFFFFFF);
      chk(SELECT_OFS, 32'h06000000);
      $display("register test done");
      // Write a word into each chain, then read it back
      for (int k = 0; k < 3; k++) begin
         wr_reg(DATA_OFS, pat[k]);
         wr_reg(SELECT_OFS, {5'h00, code[k], 25'h0000000});
         wr_reg(CONTROL_OFS, 32'h40000020);
         wr_reg(SELECT_OFS, 32'h00000000);
         chk(SELECT_OFS, {5'h00, code[k], 25'h0000000});
         poll();
         chk(CONTROL_OFS, 32'h00000020);
         chk(DATA_OFS, pat[k]);
         wr_reg(DATA_OFS, 32'h00000000);
         wr_reg(CONTROL_OFS, rcmd[k]);
         poll();
         chk(DATA_OFS, k == 2 ? pat[k] & 32'hFFFFFF00 : pat[k]);
      end
      $display("chain test done");
      // Reserved select and zero count finish without shifting
      wr_reg(SELECT_OFS, {5'h00, SEL_RSVD, 25'h0000000});
      wr_reg(DATA_OFS, 32'h000000FF);
      wr_reg(CONTROL_OFS, 32'h80000005);
      poll();
      chk(DATA_OFS, 32'h000000FF);
      wr_reg(SELECT_OFS, 32'h00000000);
      wr_reg(CONTROL_OFS, 32'h80000000);
      poll();
      chk(DATA_OFS, 32'h000000FF);
      // Reset in mid shift
      wr_reg(SELECT_OFS, 32'h06000000);
      wr_reg(CONTROL_OFS, 32'h80000010);
      reset_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      chk(SELECT_OFS, 32'h00000000);
      chk(CONTROL_OFS, 32'h00000000);
      $display("corner test done");
      complete_run();
   end
endmodule
bind pscn_scan_engine pscn_scan_engine_properties #(.CHAN_LEN(CHAN_LEN),
   .GLOBAL_LEN(GLOBAL_LEN)) u_props (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
   .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .busy_out(busy_out),
   .scan_data_in(scan_data_in), .scan_shift_en_out(scan_shift_en_out),
   .scan_data_out(scan_data_out), .scan_recirc_out(scan_recirc_out),
   .scan_update_out(scan_update_out));
`default_nettype wire
